// File: hdl/vss_regs.svh
// register map, field positions, reset values and timing limits
`ifndef VSS_REGS_SVH
`define VSS_REGS_SVH
`define VSS_OFF_MODE 12'h000
`define VSS_OFF_CTRL 12'h004
`define VSS_OFF_WG0 12'h008
`define VSS_OFF_WG3 12'h00c
`define VSS_OFF_TXBUF 12'h010
`define VSS_OFF_RXBUF 12'h014
`define VSS_OFF_STAT 12'h018
`define VSS_OFF_AUXCTL 12'h01c
`define VSS_OFF_AUXFLG 12'h020
`define VSS_MODE_UNIT 1:0
`define VSS_MODE_EXT 2
`define VSS_MODE_MSB 3
`define VSS_MODE_POL 4
`define VSS_MODE_TXC 5
`define VSS_CTRL_TXEN 0
`define VSS_CTRL_RXEN 1
`define VSS_CTRL_LEN 6:4
`define VSS_STAT_TXE 0
`define VSS_STAT_DONE 1
`define VSS_STAT_RXF 2
`define VSS_STAT_OVR 3
`define VSS_STAT_BUSY 4
`define VSS_RST_MODE 6'h00
`define VSS_RST_CTRL 7'h00
`define VSS_RST_WG 16'h0000
`define VSS_MIN_PER_DUPLEX 6
`define VSS_MIN_PER_OTHER 20
`endif

// File: hdl/vss_pkg.sv
// shared types of the variable length serial port
package vss_pkg;
  typedef enum logic [1:0]
  {
    vss_st_idle = 2'b00,
    vss_st_shift = 2'b01,
    vss_st_done = 2'b11
  } vss_state_t;
  typedef enum logic [1:0]
  {
    vss_unit_reset = 2'b00,
    vss_unit_sync = 2'b01,
    vss_unit_alt = 2'b10
  } vss_unit_t;
endpackage : vss_pkg

// File: hdl/vss_sync.sv
// two flip-flop synchroniser for the serial pins
`timescale 1ns/1ps
module vss_sync
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // asynchronous in, synchronised out
  input wire logic [1:0] d,
  output logic [1:0] q
);
  logic [1:0] meta_r;
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_bit
      // first stage feeds only the second stage
      always_ff @(posedge clock)
      begin
        if (reset)
        begin
          meta_r[i] <= 1'b1;
          q[i] <= 1'b1;
        end
        else
        begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule : vss_sync

// File: hdl/vss_top.sv
// variable length clock synchronous serial port with apb registers
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "vss_regs.svh"
////////////////////////////////////////////////////////////////////////
// Contract
// R1: polarity reverse inverts all output and input bits
// R2: software keeps polarity bit zero for normal use
// R3: two internal 8-bit shift registers
// R4: base timer wraps every k+2 counts
// R5: channel 2 clock, channel 3 holds (k+2)/2
// R6: external clock sets rate, period at least 20
// R7: internal clock period at least 6 or 20
// R8: transmit needs enable and written buffer
// R9: receive needs both enables and written buffer
// R10: transmit event on empty or on completion
// R11: receive event when data reaches buffer
// R12: overrun when new word meets unread buffer
// R13: first bit is bit 0 or bit 7
// R14: frame length programmable from 1 to 8
// R15: only channels 0, 2 and 3 used here
// R16: alt bus flags write-zero, cleared by control bit
// R17: receive flags clear in unit reset, rx disabled
// R18: slave timing uses 32.5 us, never 170 us
// R19: clock select bit 0 internal, 1 external
// R20: data output high until first transmission
// R21: one bit per clock, buffer loaded after count
// R22: drive on falling edge, sample on rising edge
module vss_top
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  output logic serial_data_out_pin,
  input wire logic serial_data_in_pin,
  input wire logic transfer_clock_pin_i,
  output logic transfer_clock_pin_o,
  output logic transfer_clock_pin_oe,
  // events
  output logic tx_event,
  output logic rx_event,
  input wire logic [1:0] alt_cause
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [5:0] mode_r;
  logic [6:0] ctrl_r;
  logic [15:0] wg0_r;
  logic [15:0] wg3_r;
  logic [7:0] txbuf_r;
  logic txfull_r;
  logic [7:0] rxbuf_r;
  logic rxfull_r;
  logic ovr_r;
  logic done_r;
  logic auxen_r;
  logic [1:0] aux_r;
  vss_pkg::vss_state_t state_r;
  logic [15:0] cnt_r;
  logic [2:0] bit_r;
  logic [7:0] txs_r;
  logic [7:0] rxs_r;
  logic sampled_r;
  logic sdo_r;
  logic sclk_r;
  logic clk_prev_r;
  logic [31:0] prdata_r;
  logic tx_event_r;
  logic rx_event_r;
  logic [1:0] syn;
  logic wr;
  logic rd_rx;
  logic mapped;
  logic sync_mode;
  logic ext;
  logic msb;
  logic pol;
  logic [2:0] len_m1;
  logic start;
  logic rise;
  logic fall;
  logic last_cnt;
  logic unit_clr;

  // bit position of the n-th transferred bit
  function automatic logic [2:0] bit_index(input logic m,
                                           input logic [2:0] n);
    bit_index = m ? (3'h7 - n) : n; // R13
  endfunction : bit_index

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser: data in bit 0, transfer clock in bit 1
  vss_sync vss_sync_i
  (
    .clock(clock),
    .reset(reset),
    .d({transfer_clock_pin_i, serial_data_in_pin}),
    .q(syn)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode of bus and mode fields
  assign wr = psel && penable && pwrite;
  assign rd_rx = psel && penable && !pwrite && paddr == `VSS_OFF_RXBUF;
  assign sync_mode = mode_r[`VSS_MODE_UNIT] == vss_pkg::vss_unit_sync;
  assign unit_clr = mode_r[`VSS_MODE_UNIT] == vss_pkg::vss_unit_reset;
  assign ext = mode_r[`VSS_MODE_EXT]; // R19
  assign msb = mode_r[`VSS_MODE_MSB];
  assign pol = mode_r[`VSS_MODE_POL];
  assign len_m1 = ctrl_r[`VSS_CTRL_LEN]; // R14
  assign start = state_r == vss_pkg::vss_st_idle && sync_mode &&
                 ctrl_r[`VSS_CTRL_TXEN] && txfull_r; // R8
  assign last_cnt = {1'b0, cnt_r} == ({1'b0, wg0_r} + 17'h00001);
  // transfer clock edges, internal timer or synchronised pin
  assign rise = ext ? (syn[1] && !clk_prev_r) : (cnt_r == wg3_r); // R6
  assign fall = ext ? (!syn[1] && clk_prev_r) : (cnt_r == 16'h0000);
  always_comb
  begin
    case (paddr)
      `VSS_OFF_MODE, `VSS_OFF_CTRL, `VSS_OFF_WG0, `VSS_OFF_WG3,
      `VSS_OFF_TXBUF, `VSS_OFF_RXBUF, `VSS_OFF_STAT,
      `VSS_OFF_AUXCTL, `VSS_OFF_AUXFLG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // read data captured in the setup phase
  always_ff @(posedge clock)
  begin
    if (reset)
      prdata_r <= 32'h00000000;
    else if (psel && !penable)
    begin
      case (paddr)
        `VSS_OFF_MODE: prdata_r <= {26'h0000000, mode_r};
        `VSS_OFF_CTRL: prdata_r <= {25'h0000000, ctrl_r};
        `VSS_OFF_WG0: prdata_r <= {16'h0000, wg0_r};
        `VSS_OFF_WG3: prdata_r <= {16'h0000, wg3_r};
        `VSS_OFF_TXBUF: prdata_r <= {24'h000000, txbuf_r};
        `VSS_OFF_RXBUF: prdata_r <= {24'h000000, rxbuf_r};
        `VSS_OFF_STAT: prdata_r <= {27'h0000000,
                                    state_r != vss_pkg::vss_st_idle,
                                    ovr_r, rxfull_r, done_r, !txfull_r};
        `VSS_OFF_AUXCTL: prdata_r <= {31'h00000000, auxen_r};
        `VSS_OFF_AUXFLG: prdata_r <= {30'h00000000, aux_r};
        default: prdata_r <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      mode_r <= `VSS_RST_MODE;
      ctrl_r <= `VSS_RST_CTRL;
      wg0_r <= `VSS_RST_WG;
      wg3_r <= `VSS_RST_WG;
      auxen_r <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == `VSS_OFF_MODE)
        mode_r <= pwdata[5:0];
      if (paddr == `VSS_OFF_CTRL)
        ctrl_r <= pwdata[6:0];
      if (paddr == `VSS_OFF_WG0)
        wg0_r <= pwdata[15:0]; // R4
      if (paddr == `VSS_OFF_WG3)
        wg3_r <= pwdata[15:0]; // R5
      if (paddr == `VSS_OFF_AUXCTL)
        auxen_r <= pwdata[0];
    end
  end

  // alternate bus cause flags: only zero writes land, held clear by control
  always_ff @(posedge clock)
  begin
    if (reset)
      aux_r <= 2'b00;
    else if (!auxen_r)
      aux_r <= 2'b00; // R16
    else if (wr && paddr == `VSS_OFF_AUXFLG)
      aux_r <= (aux_r & pwdata[1:0]) | alt_cause; // R16
    else
      aux_r <= aux_r | alt_cause;
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit buffer: filled by software, emptied at frame start
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      txbuf_r <= 8'h00;
      txfull_r <= 1'b0;
    end
    else if (wr && paddr == `VSS_OFF_TXBUF)
    begin
      txbuf_r <= pwdata[7:0];
      txfull_r <= 1'b1;
    end
    else if (start)
      txfull_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // base timer: channel 0 wraps it, channel 2 shapes the clock
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cnt_r <= 16'h0000;
      sclk_r <= 1'b1;
    end
    else if (state_r == vss_pkg::vss_st_shift && !ext)
    begin
      cnt_r <= last_cnt ? 16'h0000 : cnt_r + 16'h0001; // R4 R15
      if (cnt_r == 16'h0000)
        sclk_r <= 1'b0; // R5
      else if (cnt_r == wg3_r)
        sclk_r <= 1'b1;
    end
    else
    begin
      cnt_r <= 16'h0000;
      sclk_r <= 1'b1;
    end
  end

  // previous synchronised clock level for edge detection
  always_ff @(posedge clock)
  begin
    if (reset)
      clk_prev_r <= 1'b1;
    else
      clk_prev_r <= syn[1];
  end

  assign transfer_clock_pin_o = sclk_r;
  assign transfer_clock_pin_oe = sync_mode && !ext; // R19

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer and the two shift registers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r <= vss_pkg::vss_st_idle;
      bit_r <= 3'h0;
      txs_r <= 8'h00;
      rxs_r <= 8'h00;
      sampled_r <= 1'b0;
      sdo_r <= 1'b1;
    end
    else if (!sync_mode)
    begin
      state_r <= vss_pkg::vss_st_idle;
      sampled_r <= 1'b0;
      sdo_r <= 1'b1; // R20
    end
    else
    begin
      case (state_r)
        vss_pkg::vss_st_idle:
        begin
          if (start)
          begin
            state_r <= vss_pkg::vss_st_shift;
            txs_r <= txbuf_r; // R3
            bit_r <= 3'h0;
            sampled_r <= 1'b0;
            sdo_r <= txbuf_r[bit_index(msb, 3'h0)] ^ pol; // R1
          end
        end
        vss_pkg::vss_st_shift:
        begin
          if (!ctrl_r[`VSS_CTRL_TXEN])
            state_r <= vss_pkg::vss_st_idle;
          else if (rise)
          begin
            if (ctrl_r[`VSS_CTRL_RXEN])
              rxs_r[bit_index(msb, bit_r)] <= syn[0] ^ pol; // R1 R9 R22
            if (bit_r == len_m1)
              state_r <= vss_pkg::vss_st_done; // R21
            else
            begin
              bit_r <= bit_r + 3'h1; // R21
              sampled_r <= 1'b1;
            end
          end
          else if (fall && sampled_r)
          begin
            sdo_r <= txs_r[bit_index(msb, bit_r)] ^ pol; // R1 R22
            sampled_r <= 1'b0;
          end
        end
        vss_pkg::vss_st_done:
          state_r <= vss_pkg::vss_st_idle;
        default:
          state_r <= vss_pkg::vss_st_idle;
      endcase
    end
  end

  assign serial_data_out_pin = sdo_r;

  ////////////////////////////////////////////////////////////////////////
  // receive buffer, full and overrun flags; set wins over clear
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rxbuf_r <= 8'h00;
      rxfull_r <= 1'b0;
      ovr_r <= 1'b0;
    end
    else if (state_r == vss_pkg::vss_st_done && ctrl_r[`VSS_CTRL_RXEN])
    begin
      rxbuf_r <= rxs_r; // R21
      rxfull_r <= 1'b1;
      if (rxfull_r && !rd_rx)
        ovr_r <= 1'b1; // R12
    end
    else
    begin
      if (rd_rx)
        rxfull_r <= 1'b0;
      if (wr && paddr == `VSS_OFF_STAT && pwdata[`VSS_STAT_OVR])
        ovr_r <= 1'b0;
      if (unit_clr && !ctrl_r[`VSS_CTRL_RXEN])
      begin
        rxfull_r <= 1'b0; // R17
        ovr_r <= 1'b0; // R17
      end
    end
  end

  // transmit completion flag, cleared by a buffer write
  always_ff @(posedge clock)
  begin
    if (reset)
      done_r <= 1'b0;
    else if (state_r == vss_pkg::vss_st_done)
      done_r <= 1'b1;
    else if (wr && paddr == `VSS_OFF_TXBUF)
      done_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // event pulses
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      tx_event_r <= 1'b0;
      rx_event_r <= 1'b0;
    end
    else
    begin
      tx_event_r <= mode_r[`VSS_MODE_TXC] ?
                    state_r == vss_pkg::vss_st_done : start; // R10
      rx_event_r <= state_r == vss_pkg::vss_st_done &&
                    ctrl_r[`VSS_CTRL_RXEN]; // R11
    end
  end

  assign tx_event = tx_event_r;
  assign rx_event = rx_event_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_idle_high;
    !sync_mode |=> serial_data_out_pin;
  endproperty
  a_idle_high: assert property (p_idle_high) // R20
    else $error("data output not high outside transfer mode");

  property p_start_cond;
    state_r == vss_pkg::vss_st_idle ##1 state_r == vss_pkg::vss_st_shift
    |-> $past(ctrl_r[`VSS_CTRL_TXEN]) && $past(txfull_r);
  endproperty
  a_start_cond: assert property (p_start_cond) // R8
    else $error("frame started without enable and data");

  property p_tx_event;
    state_r == vss_pkg::vss_st_done && mode_r[`VSS_MODE_TXC]
    |=> tx_event;
  endproperty
  a_tx_event: assert property (p_tx_event) // R10
    else $error("missing transmit completion event");

  property p_rx_event;
    state_r == vss_pkg::vss_st_done && ctrl_r[`VSS_CTRL_RXEN]
    |=> rx_event && rxfull_r && rxbuf_r == $past(rxs_r);
  endproperty
  a_rx_event: assert property (p_rx_event) // R11
    else $error("receive buffer not loaded with event");

  property p_overrun;
    state_r == vss_pkg::vss_st_done && ctrl_r[`VSS_CTRL_RXEN] &&
    rxfull_r && !rd_rx |=> ovr_r;
  endproperty
  a_overrun: assert property (p_overrun) // R12
    else $error("overrun not flagged");

  property p_wrap;
    state_r == vss_pkg::vss_st_shift && !ext && last_cnt
    ##1 state_r == vss_pkg::vss_st_shift |-> cnt_r == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) // R4
    else $error("base timer did not wrap at k+2");

  property p_len;
    state_r == vss_pkg::vss_st_shift |-> bit_r <= len_m1;
  endproperty
  a_len: assert property (p_len) // R14
    else $error("bit count beyond frame length");

  property p_unit_clear;
    unit_clr && !ctrl_r[`VSS_CTRL_RXEN] |=> !rxfull_r && !ovr_r;
  endproperty
  a_unit_clear: assert property (p_unit_clear) // R17
    else $error("receive flags not cleared in unit reset");

  property p_rx_needs_tx;
    rx_event |-> $past(ctrl_r[`VSS_CTRL_TXEN], 2);
  endproperty
  a_rx_needs_tx: assert property (p_rx_needs_tx) // R9
    else $error("reception without transmit enable");
endmodule : vss_top

// File: sim/vss_peer.sv
// serial peer model facing the variable length serial port
`timescale 1ns/1ps
module vss_peer
(
  // base clock
  input wire logic clock,
  // device side of the link
  input wire logic clk_o,
  input wire logic clk_oe,
  input wire logic dout,
  // lines the peer drives
  output logic din,
  output logic clk_line
);
  logic ext_clk;
  logic [7:0] send_bits;
  logic [7:0] got_bits;
  int idx;
  int len;
  ////////////////////////////////////////////////////////////////////////
  // pin level from whichever side drives the clock
  assign clk_line = clk_oe ? clk_o : ext_clk;
  initial
  begin
    ext_clk = 1'b1;
    din = 1'b1;
    idx = 0;
    len = 0;
  end
  // load a frame, bits listed in time order
  task arm(input logic [7:0] s, input int l);
    send_bits = s;
    len = l;
    idx = 0;
    got_bits = 8'h00;
  endtask : arm
  // outside clock, 24 base cycles a bit, high between frames
  task ext_frame(input int n);
    repeat (n)
    begin
      repeat (12) @(posedge clock);
      ext_clk <= 1'b0;
      repeat (12) @(posedge clock);
      ext_clk <= 1'b1;
    end
  endtask : ext_frame
  ////////////////////////////////////////////////////////////////////////
  // next bit on the falling edge
  always @(negedge clk_line)
    if (idx < len)
      din <= send_bits[idx];
  // capture on the rising edge, then invert din 6 base cycles after the last bit
  always @(posedge clk_line)
  begin
    if (idx < len)
    begin
      got_bits[idx] = dout;
      idx++;
      if (idx == len)
      begin
        repeat (6) @(posedge clock);
        din <= ~din;
      end
    end
  end
endmodule : vss_peer

// File: sim/vss_top_bench.sv
// self checking bench for the variable length serial port
`timescale 1ns/1ps
`include "vss_regs.svh"
module vss_top_bench;
  logic clock, reset, psel, penable, pwrite, err, prev_ck;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sdo, sdi, ck_o, ck_oe, ck_line;
  logic tx_event, rx_event;
  logic [1:0] alt_cause;
  int miscompares, checks_done, tx_seen, rx_seen, tx_rx, gap, per;
  ////////////////////////////////////////////////////////////////////////
  // design and peer
  vss_top vss_top_i (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_data_out_pin(sdo), .serial_data_in_pin(sdi),
    .transfer_clock_pin_i(ck_line), .transfer_clock_pin_o(ck_o),
    .transfer_clock_pin_oe(ck_oe), .tx_event(tx_event),
    .rx_event(rx_event), .alt_cause(alt_cause));
  vss_peer vss_peer_i (.clock(clock), .clk_o(ck_o), .clk_oe(ck_oe),
    .dout(sdo), .din(sdi), .clk_line(ck_line));
  ////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // event counts and transfer clock period
  always @(posedge clock)
  begin
    if (rx_event === 1'b1)
      rx_seen++;
    if (tx_event === 1'b1)
      tx_rx = rx_seen;
    if (tx_event === 1'b1)
      tx_seen++;
    gap++;
    if (prev_ck === 1'b1 && ck_o === 1'b0)
    begin
      per = gap;
      gap = 0;
    end
    prev_ck = ck_o;
  end
  ////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, held until pready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // no limit of its own: only the watchdog ends a stuck access
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  function logic [31:0] md(input logic e, m, p, t);
    return {26'h0, t, p, m, e, 2'b01};
  endfunction : md
  function logic [31:0] ctl(input logic t, r, input int l);
    return {25'h0, 3'(l - 1), 2'b00, r, t};
  endfunction : ctl
  // wait until the port is idle again
  task go(input logic ext, input int l);
    if (ext)
      vss_peer_i.ext_frame(l);
    repeat (2) @(posedge clock);
    // a port that never goes idle is caught by the watchdog
    do
    begin
      xfer(1'b0, `VSS_OFF_STAT, 32'h0);
    end
    while (rd[4] !== 1'b0);
    repeat (4) @(posedge clock);
  endtask : go
  task frame(input logic [7:0] d, s, input int l, input logic ext);
    vss_peer_i.arm(s, l);
    xfer(1'b1, `VSS_OFF_TXBUF, {24'h0, d});
    go(ext, l);
  endtask : frame
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    wrap_up;
  end
  // test sequence
  initial
  begin
    {reset, psel, penable, pwrite, paddr, pwdata, alt_cause} = '0;
    {miscompares, checks_done, tx_seen, rx_seen, tx_rx, gap} = '0;
    reset = 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    check(sdo, 1);
    check(ck_oe, 0);
    xfer(1'b0, `VSS_OFF_MODE, 32'h0);
    check(rd, 0);
    xfer(1'b0, `VSS_OFF_WG0, 32'h0);
    check(rd, 0);
    xfer(1'b0, 12'h040, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    xfer(1'b1, `VSS_OFF_WG0, 32'h8);
    xfer(1'b1, `VSS_OFF_WG3, 32'h5);
    xfer(1'b1, `VSS_OFF_MODE, md(0, 0, 0, 1));
    @(negedge clock);
    check(ck_oe, 1);
    xfer(1'b1, `VSS_OFF_CTRL, ctl(1, 1, 8));
    frame(8'ha5, 8'h3c, 8, 0);
    check(vss_peer_i.got_bits, 8'ha5);
    check(per, 10);
    xfer(1'b0, `VSS_OFF_RXBUF, 32'h0);
    check(rd[7:0], 8'h3c);
    check(rx_seen, 1);
    check(tx_seen, 1);
    xfer(1'b1, `VSS_OFF_MODE, md(0, 1, 0, 1));
    xfer(1'b1, `VSS_OFF_CTRL, ctl(1, 1, 3));
    frame(8'ha0, 8'h06, 3, 0);
    check(vss_peer_i.got_bits, 8'h05);
    xfer(1'b0, `VSS_OFF_RXBUF, 32'h0);
    check(rd[7:5], 3'b011);
    xfer(1'b1, `VSS_OFF_MODE, md(0, 0, 1, 1));
    xfer(1'b1, `VSS_OFF_CTRL, ctl(1, 1, 8));
    frame(8'h0f, 8'h55, 8, 0);
    check(vss_peer_i.got_bits, 8'hf0);
    xfer(1'b0, `VSS_OFF_RXBUF, 32'h0);
    check(rd[7:0], 8'haa);
    xfer(1'b1, `VSS_OFF_MODE, md(0, 0, 0, 0));
    frame(8'h33, 8'h11, 8, 0);
    check(tx_rx, 3);
    check(rx_seen, 4);
    xfer(1'b1, `VSS_OFF_CTRL, ctl(1, 0, 8));
    frame(8'h44, 8'h00, 8, 0);
    check(rx_seen, 4);
    xfer(1'b1, `VSS_OFF_CTRL, ctl(0, 1, 8));
    xfer(1'b1, `VSS_OFF_TXBUF, 32'h81);
    repeat (60) @(posedge clock);
    check(tx_seen, 5);
    vss_peer_i.arm(8'h7e, 8);
    xfer(1'b1, `VSS_OFF_CTRL, ctl(1, 1, 8));
    go(0, 8);
    check(vss_peer_i.got_bits, 8'h81);
    xfer(1'b0, `VSS_OFF_STAT, 32'h0);
    check(rd[3:2], 2'b11);
    xfer(1'b1, `VSS_OFF_STAT, 32'h8);
    xfer(1'b0, `VSS_OFF_STAT, 32'h0);
    check(rd[3:2], 2'b01);
    xfer(1'b1, `VSS_OFF_MODE, 32'h0);
    xfer(1'b1, `VSS_OFF_CTRL, 32'h0);
    xfer(1'b0, `VSS_OFF_STAT, 32'h0);
    check(rd[3:2], 2'b00);
    xfer(1'b1, `VSS_OFF_MODE, md(1, 0, 0, 1));
    @(negedge clock);
    check(ck_oe, 0);
    xfer(1'b1, `VSS_OFF_CTRL, ctl(1, 1, 8));
    frame(8'h5a, 8'h96, 8, 1);
    check(vss_peer_i.got_bits, 8'h5a);
    xfer(1'b0, `VSS_OFF_RXBUF, 32'h0);
    check(rd[7:0], 8'h96);
    // alternate bus cause flags: set by events, zero writes, held clear
    xfer(1'b1, `VSS_OFF_AUXCTL, 32'h1);
    alt_cause <= 2'b10;
    @(posedge clock);
    alt_cause <= 2'b00;
    xfer(1'b0, `VSS_OFF_AUXFLG, 32'h0);
    check(rd[1:0], 2'b10);
    xfer(1'b1, `VSS_OFF_AUXFLG, 32'h3);
    xfer(1'b0, `VSS_OFF_AUXFLG, 32'h0);
    check(rd[1:0], 2'b10);
    xfer(1'b1, `VSS_OFF_AUXFLG, 32'h0);
    xfer(1'b0, `VSS_OFF_AUXFLG, 32'h0);
    check(rd[1:0], 2'b00);
    alt_cause <= 2'b01;
    @(posedge clock);
    alt_cause <= 2'b00;
    xfer(1'b0, `VSS_OFF_AUXFLG, 32'h0);
    check(rd[1:0], 2'b01);
    xfer(1'b1, `VSS_OFF_AUXCTL, 32'h0);
    xfer(1'b0, `VSS_OFF_AUXFLG, 32'h0);
    check(rd[1:0], 2'b00);
    wrap_up;
  end
endmodule : vss_top_bench
